// file: rtl/bcc_pkg.sv
/*
  Constants, register map and types for the converter control block.
  Assumes a 100 MHz reference clock and a 32-bit APB master.
*/
// Overview of operation
// - Auto mode: PWM at load near 600 mA or above, PFM below unless forced PWM.
// - Forced PWM keeps fixed frequency at every load, never PFM.
// - Force multiphase bit forces dual-phase and also forces PWM.
// - Without forced dual-phase, phases are added or shed by load current.
// - Dual-phase heavy load: phases switch 180 degrees apart.
// - Only two configurations: dual-phase (core 0 master) or two single-phase.
// - Dual-phase ignores slave settings except discharge, current limit and its irq.
// - Any write to measurement select outside the OTP state starts measurement on the chosen core.
// - Measured core forced to PWM; sequence done within 50 us.
// - Measurement end sets a done flag, maskable by its own mask bit.
// - 9-bit result: bits 7:0 in first result register, bit 8 in second.
// - One code step is 20 mA; maximum code is 10.22 A.
// - Dual-phase result is master plus slave phase currents.
// - Spread spectrum on both cores only when enabled and PLL disabled.
// - Five-bit field sets external clock frequency, 1 to 24 MHz.
// - External clock valid only within -30%/+10% of nominal.
// - PLL enable 0: PLL and detector off, no clock irq, RC clock used.
// - PLL enable 1: irq on clock appear/disappear, auto switch while valid.
// - A mask bit in the top mask register suppresses the sync clock irq.
// - PLL enabled: irq if no clock at OTP-to-standby or standby-to-active; PLL enable is always 0 in OTP state, so only standby-to-active does.
// - After power-on key settings take defaults from OTP bits.
// - External clock nominal frequency lies in whole MHz from 1 to 24.
package bcc_pkg;
  // Register byte offsets
  localparam logic [7:0] MASTER_CTRL_ONE_OFS = 8'h00;
  localparam logic [7:0] MASTER_CTRL_TWO_OFS = 8'h04;
  localparam logic [7:0] SLAVE_CTRL_ONE_OFS  = 8'h08;
  localparam logic [7:0] SLAVE_CTRL_TWO_OFS  = 8'h0c;
  localparam logic [7:0] CONFIG_OFS          = 8'h10;
  localparam logic [7:0] PLL_CTRL_OFS        = 8'h14;
  localparam logic [7:0] IRQ_FLAGS_OFS       = 8'h18;
  localparam logic [7:0] IRQ_MASK_OFS        = 8'h1c;
  localparam logic [7:0] MEAS_SEL_OFS        = 8'h20;
  localparam logic [7:0] RESULT_LO_OFS       = 8'h24;
  localparam logic [7:0] RESULT_HI_OFS       = 8'h28;
  localparam logic [7:0] STATUS_OFS          = 8'h2c;
  // Control one fields
  localparam int CTRL_FPWM_BIT  = 0;
  localparam int CTRL_FMP_BIT   = 1;
  localparam int CTRL_RDIS_BIT  = 2;
  // Config and PLL fields
  localparam int CFG_SPREAD_BIT = 0;
  localparam int PLL_EN_BIT     = 7;
  // Flag and mask bit positions
  localparam int IRQ_MEAS_BIT   = 0;
  localparam int IRQ_SYNC_BIT   = 1;
  localparam int IRQ_SLAVE_CURRENT_LIMIT_BIT  = 2;
  localparam int IRQ_ILIM0_BIT  = 3;
  // Status bit positions
  localparam int ST_PWM0_BIT    = 0;
  localparam int ST_PWM1_BIT    = 1;
  localparam int ST_DUAL_BIT    = 2;
  localparam int ST_EXTCLK_BIT  = 3;
  localparam int ST_SPREAD_BIT  = 4;
  localparam int ST_BUSY_BIT    = 5;
  localparam int ST_VALID_BIT   = 6;
  localparam int ST_INTERLV_BIT = 7;
  // Load current thresholds in 20 mA codes
  localparam int          CODE_MA       = 20;
  localparam int          PWM_ENTRY_MA  = 600;
  localparam logic [8:0]  PWM_THR_CODE  = 9'(PWM_ENTRY_MA / CODE_MA);
  localparam logic [8:0]  DUAL_THR_CODE = 9'h064;
  // Measurement time
  localparam int          MEAS_TIME_US  = 50;
  localparam int          CLK_MHZ       = 100;
  localparam int          MEAS_CYCLES   = MEAS_TIME_US * CLK_MHZ;
  // Clock detector window and tolerances in percent
  localparam int          DET_WIN_US    = 10;
  localparam int          DET_WIN_CYC   = DET_WIN_US * CLK_MHZ;
  localparam int          TOL_LO_PCT    = 70;
  localparam int          TOL_HI_PCT    = 110;
  localparam logic [4:0]  FREQ_MIN_MHZ  = 5'h01;
  localparam logic [4:0]  FREQ_MAX_MHZ  = 5'h18;
  localparam logic [4:0]  FREQ_RST      = 5'h01;
  // Device operating states and measurement sequence states
  typedef enum logic [1:0] {ST_OTP, ST_STANDBY, ST_ACTIVE} bcc_dev_type;
  typedef enum logic [1:0] {MS_IDLE, MS_RUN} bcc_meas_type;
endpackage : bcc_pkg

// file: rtl/bcc_top.sv
/*
  Digital control for two buck cores: mode choice, phase control,
  load current measurement, spread spectrum gate and sync clock detector.
  Assumes an APB master on REF_CLK_I, analog current samples on the same
  clock, and the external sync clock arriving asynchronously on a pin.
*/
`timescale 1ns/1ps
`default_nettype none
module bcc_top
  import bcc_pkg::*;
#(
  parameter int MEAS_CYC = MEAS_CYCLES
) (
  // Clock and reset
  input  wire  logic        REF_CLK_I,
  input  wire  logic        RST_B_I,
  // APB slave
  input  wire  logic        PSEL_I,
  input  wire  logic        PENABLE_I,
  input  wire  logic        PWRITE_I,
  input  wire  logic [7:0]  PADDR_I,
  input  wire  logic [31:0] PWDATA_I,
  output logic [31:0]       PRDATA_O,
  output logic              PREADY_O,
  output logic              PSLVERR_O,
  // OTP defaults and sequencing
  input  wire  logic        OTP_DONE_I,
  input  wire  logic [7:0]  OTP_CTRL0_I,
  input  wire  logic [7:0]  OTP_CTRL1_I,
  input  wire  logic [7:0]  OTP_ILIM_I,
  input  wire  logic        ACTIVE_REQ_I,
  // Analog side
  input  wire  logic [8:0]  LOAD0_I,
  input  wire  logic [8:0]  LOAD1_I,
  input  wire  logic        ILIM0_EVT_I,
  input  wire  logic        SLAVE_CURRENT_LIMIT_EVT_I,
  input  wire  logic        SYNC_CLOCK_INPUT_I,
  // Converter controls
  output logic              PWM0_O,
  output logic              PWM1_O,
  output logic              DUAL_PHASE_O,
  output logic              PHASE1_ON_O,
  output logic              INTERLEAVE_180_O,
  output logic              SPREAD_O,
  output logic              EXT_CLK_SEL_O,
  output logic              PLL_ON_O,
  output logic              DISCHARGE1_O,
  output logic [2:0]        SLAVE_CURRENT_LIMIT_O,
  output logic              IRQ_O
);
  logic [7:0]  master_control_one_r, master_control_two_r;
  logic [7:0]  slave_control_one_r, slave_control_two_r;
  logic [7:0]  config_r, pll_ctrl_r, mask_r, flags_r;
  logic        sel_r;
  logic [8:0]  result_r;
  logic        valid_r;
  bcc_dev_type dev_r;
  bcc_meas_type meas_r;
  logic [15:0] meas_cnt_r;
  logic        meas_core_r;
  logic        wr, rd;
  logic        meas_start, meas_done;
  logic [7:0]  set_vec;
  logic        dual_mode, dual_cfg;

  assign wr = PSEL_I && PENABLE_I && PWRITE_I;
  assign rd = PSEL_I && !PENABLE_I && !PWRITE_I; // Read address taken in setup
  assign PREADY_O = 1'b1;
  assign PSLVERR_O = 1'b0;
  assign dual_cfg  = config_r[1];
  assign dual_mode = master_control_one_r[CTRL_FMP_BIT] | dual_cfg;

  // OTP load, then device state
  always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      dev_r <= ST_OTP;
    end else begin
      unique case (dev_r)
        ST_OTP:     if (OTP_DONE_I) dev_r <= ST_STANDBY;
        ST_STANDBY: if (ACTIVE_REQ_I) dev_r <= ST_ACTIVE;
        ST_ACTIVE:  if (!ACTIVE_REQ_I) dev_r <= ST_STANDBY;
      endcase
    end
  end

  // Control registers, OTP defaults on leaving the OTP state
  always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      master_control_one_r <= 8'h00;
      master_control_two_r <= 8'h00;
      slave_control_one_r  <= 8'h00;
      slave_control_two_r  <= 8'h00;
      config_r             <= 8'h00;
      pll_ctrl_r           <= {3'h0, FREQ_RST};
      mask_r               <= 8'h00;
    end else if (dev_r == ST_OTP) begin
      if (OTP_DONE_I) begin
        master_control_one_r <= OTP_CTRL0_I;
        slave_control_one_r  <= OTP_CTRL1_I;
        master_control_two_r <= OTP_ILIM_I;
        slave_control_two_r  <= OTP_ILIM_I;
      end
    end else if (wr) begin
      unique case (PADDR_I)
        MASTER_CTRL_ONE_OFS: master_control_one_r <= PWDATA_I[7:0];
        MASTER_CTRL_TWO_OFS: master_control_two_r <= PWDATA_I[7:0];
        SLAVE_CTRL_ONE_OFS:  slave_control_one_r  <= PWDATA_I[7:0];
        SLAVE_CTRL_TWO_OFS:  slave_control_two_r  <= PWDATA_I[7:0];
        CONFIG_OFS:          config_r             <= PWDATA_I[7:0];
        PLL_CTRL_OFS: begin
          pll_ctrl_r[PLL_EN_BIT] <= PWDATA_I[PLL_EN_BIT];
          if (PWDATA_I[4:0] >= FREQ_MIN_MHZ && PWDATA_I[4:0] <= FREQ_MAX_MHZ) begin
            pll_ctrl_r[4:0] <= PWDATA_I[4:0];
          end
        end
        IRQ_MASK_OFS:        mask_r               <= PWDATA_I[7:0];
        default: ;
      endcase
    end
  end

  // Measurement select and sequence
  assign meas_start = wr && (PADDR_I == MEAS_SEL_OFS) && (dev_r != ST_OTP);
  assign meas_done  = (meas_r == MS_RUN) && (meas_cnt_r == 16'(MEAS_CYC - 1));

  always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      sel_r       <= 1'b0;
      meas_r      <= MS_IDLE;
      meas_cnt_r  <= 16'h0000;
      meas_core_r <= 1'b0;
    end else begin
      if (meas_start) begin
        sel_r       <= PWDATA_I[0];
        meas_core_r <= PWDATA_I[0];
        meas_r      <= MS_RUN;
        meas_cnt_r  <= 16'h0000;
      end else if (meas_done) begin
        meas_r <= MS_IDLE;
      end else if (meas_r == MS_RUN) begin
        meas_cnt_r <= meas_cnt_r + 16'h0001;
      end
    end
  end

  // Result: 20 mA per code, summed in dual-phase, held until next done
  logic [9:0] sum;
  logic [8:0] sample;
  always_comb begin
    sum = {1'b0, LOAD0_I} + {1'b0, LOAD1_I};
    if (dual_mode) begin
      sample = sum[9] ? 9'h1ff : sum[8:0];
    end else begin
      sample = meas_core_r ? LOAD1_I : LOAD0_I;
    end
  end

  always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      result_r <= 9'h000;
      valid_r  <= 1'b0;
    end else if (meas_done) begin
      result_r <= sample;
      valid_r  <= 1'b1;
    end
  end

  // Operating configuration and mode selection
  logic fpwm0, fpwm1, pwm_auto0, pwm_auto1, two_phase;
  assign fpwm0 = master_control_one_r[CTRL_FPWM_BIT]
               | master_control_one_r[CTRL_FMP_BIT];
  assign fpwm1 = dual_mode ? fpwm0 : slave_control_one_r[CTRL_FPWM_BIT];
  assign pwm_auto0 = dual_mode ? (sum >= {1'b0, PWM_THR_CODE})
                               : (LOAD0_I >= PWM_THR_CODE);
  assign pwm_auto1 = LOAD1_I >= PWM_THR_CODE;
  assign two_phase = master_control_one_r[CTRL_FMP_BIT]
                   | (sum >= {1'b0, DUAL_THR_CODE});

  always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      PWM0_O           <= 1'b0;
      PWM1_O           <= 1'b0;
      DUAL_PHASE_O     <= 1'b0;
      PHASE1_ON_O      <= 1'b0;
      INTERLEAVE_180_O <= 1'b0;
      DISCHARGE1_O     <= 1'b0;
      SLAVE_CURRENT_LIMIT_O          <= 3'h0;
    end else begin
      PWM0_O <= fpwm0 | pwm_auto0 | (meas_r == MS_RUN && !meas_core_r);
      if (dual_mode) begin
        PWM1_O <= fpwm0 | pwm_auto0 | (meas_r == MS_RUN);
      end else begin
        PWM1_O <= fpwm1 | pwm_auto1 | (meas_r == MS_RUN && meas_core_r);
      end
      DUAL_PHASE_O     <= dual_mode;
      PHASE1_ON_O      <= !dual_mode || two_phase;
      INTERLEAVE_180_O <= dual_mode && two_phase;
      DISCHARGE1_O     <= slave_control_one_r[CTRL_RDIS_BIT];
      SLAVE_CURRENT_LIMIT_O          <= slave_control_two_r[2:0];
    end
  end

  // Sync clock: two-flop synchroniser, edge count per window
  logic sync_a_r, sync_b_r, sync_c_r;
  logic [15:0] win_r;
  logic [9:0]  edges_r;
  logic        clk_ok_r, clk_ok_d_r;
  logic        pll_en;
  logic [15:0] nom, lo_lim, hi_lim;
  assign pll_en = pll_ctrl_r[PLL_EN_BIT];
  always_comb begin
    nom    = 16'(pll_ctrl_r[4:0]) * 16'(DET_WIN_US);
    lo_lim = 16'((32'(nom) * TOL_LO_PCT) / 100);
    hi_lim = 16'((32'(nom) * TOL_HI_PCT) / 100);
  end

  always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      sync_a_r   <= 1'b0;
      sync_b_r   <= 1'b0;
      sync_c_r   <= 1'b0;
      win_r      <= 16'h0000;
      edges_r    <= 10'h000;
      clk_ok_r   <= 1'b0;
      clk_ok_d_r <= 1'b0;
    end else begin
      sync_a_r   <= SYNC_CLOCK_INPUT_I;
      sync_b_r   <= sync_a_r;
      sync_c_r   <= sync_b_r;
      clk_ok_d_r <= clk_ok_r;
      if (!pll_en) begin
        win_r    <= 16'h0000;
        edges_r  <= 10'h000;
        clk_ok_r <= 1'b0;
      end else if (win_r == 16'(DET_WIN_CYC - 1)) begin
        win_r    <= 16'h0000;
        edges_r  <= 10'h000;
        clk_ok_r <= (16'(edges_r) >= lo_lim) && (16'(edges_r) <= hi_lim);
      end else begin
        win_r <= win_r + 16'h0001;
        if (sync_b_r && !sync_c_r && edges_r != 10'h3ff) edges_r <= edges_r + 10'h001;
      end
    end
  end

  assign PLL_ON_O      = pll_en;
  assign EXT_CLK_SEL_O = pll_en && clk_ok_r;
  assign SPREAD_O      = config_r[CFG_SPREAD_BIT] && !pll_en;

  // Event flags: set wins over write-one-to-clear
  logic clk_change, clk_missing;
  assign clk_change  = pll_en && (clk_ok_r != clk_ok_d_r);
  assign clk_missing = pll_en && !clk_ok_r
                     && ((dev_r == ST_OTP && OTP_DONE_I)
                      || (dev_r == ST_STANDBY && ACTIVE_REQ_I));
  always_comb begin
    set_vec = 8'h00;
    set_vec[IRQ_MEAS_BIT]  = meas_done;
    set_vec[IRQ_SYNC_BIT]  = clk_change || clk_missing;
    set_vec[IRQ_SLAVE_CURRENT_LIMIT_BIT] = SLAVE_CURRENT_LIMIT_EVT_I;
    set_vec[IRQ_ILIM0_BIT] = ILIM0_EVT_I;
  end

  always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      flags_r <= 8'h00;
    end else if (wr && PADDR_I == IRQ_FLAGS_OFS) begin
      flags_r <= (flags_r & ~PWDATA_I[7:0]) | set_vec;
    end else begin
      flags_r <= flags_r | set_vec;
    end
  end

  assign IRQ_O = |(flags_r & ~mask_r);

  // Read mux
  logic [7:0] status;
  always_comb begin
    status = 8'h00;
    status[ST_PWM0_BIT]    = PWM0_O;
    status[ST_PWM1_BIT]    = PWM1_O;
    status[ST_DUAL_BIT]    = DUAL_PHASE_O;
    status[ST_EXTCLK_BIT]  = EXT_CLK_SEL_O;
    status[ST_SPREAD_BIT]  = SPREAD_O;
    status[ST_BUSY_BIT]    = meas_r == MS_RUN;
    status[ST_VALID_BIT]   = valid_r;
    status[ST_INTERLV_BIT] = INTERLEAVE_180_O;
  end

  always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      PRDATA_O <= 32'h0000_0000;
    end else if (rd) begin
      unique case (PADDR_I)
        MASTER_CTRL_ONE_OFS: PRDATA_O <= {24'h000000, master_control_one_r};
        MASTER_CTRL_TWO_OFS: PRDATA_O <= {24'h000000, master_control_two_r};
        SLAVE_CTRL_ONE_OFS:  PRDATA_O <= {24'h000000, slave_control_one_r};
        SLAVE_CTRL_TWO_OFS:  PRDATA_O <= {24'h000000, slave_control_two_r};
        CONFIG_OFS:          PRDATA_O <= {24'h000000, config_r};
        PLL_CTRL_OFS:        PRDATA_O <= {24'h000000, pll_ctrl_r};
        IRQ_FLAGS_OFS:       PRDATA_O <= {24'h000000, flags_r};
        IRQ_MASK_OFS:        PRDATA_O <= {24'h000000, mask_r};
        MEAS_SEL_OFS:        PRDATA_O <= {31'h0, sel_r};
        RESULT_LO_OFS:       PRDATA_O <= {24'h000000, result_r[7:0]};
        RESULT_HI_OFS:       PRDATA_O <= {31'h0, result_r[8]};
        STATUS_OFS:          PRDATA_O <= {24'h000000, status};
        default:             PRDATA_O <= 32'h0000_0000;
      endcase
    end
  end

endmodule : bcc_top
`default_nettype wire

// file: verification/bcc_top_sva.sv
/*
  Port-level checks on the converter control block.
  Bound to bcc_top from the bench; one clock domain, async low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module bcc_chk (
  // Clock, reset and APB
  input wire logic        REF_CLK_I,
  input wire logic        RST_B_I,
  input wire logic        PSEL_I,
  input wire logic        PENABLE_I,
  input wire logic        PWRITE_I,
  input wire logic [7:0]  PADDR_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic        PREADY_O,
  input wire logic        PSLVERR_O,
  // Sequencing and load
  input wire logic        OTP_DONE_I,
  input wire logic [8:0]  LOAD0_I,
  // Converter controls
  input wire logic        PWM0_O,
  input wire logic        DUAL_PHASE_O,
  input wire logic        INTERLEAVE_180_O,
  input wire logic        SPREAD_O,
  input wire logic        EXT_CLK_SEL_O,
  input wire logic        PLL_ON_O,
  input wire logic        DISCHARGE1_O,
  input wire logic [2:0]  SLAVE_CURRENT_LIMIT_O
);
  logic otp_q_r;
  logic apb_wr;
  assign apb_wr = PSEL_I && PENABLE_I && PWRITE_I;
  // Defaults may land in the cycles after OTP completes
  always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      otp_q_r <= 1'b0;
    end else begin
      otp_q_r <= OTP_DONE_I;
    end
  end
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (!RST_B_I);
  bus_answer_a: assert property (PREADY_O && !PSLVERR_O)
    else $error("apb answer not ready or in error");
  spread_pll_a: assert property (PLL_ON_O |-> !SPREAD_O)
    else $error("spread spectrum active with pll on");
  rc_clock_a: assert property (!PLL_ON_O |-> !EXT_CLK_SEL_O)
    else $error("external clock selected with pll off");
  load_pwm_a: assert property ((OTP_DONE_I && LOAD0_I >= 9'h01e) [*4] |-> PWM0_O)
    else $error("core zero not in pwm at heavy load");
  slave_ilim_a: assert property ($changed(SLAVE_CURRENT_LIMIT_O) |->
    ($past(apb_wr) && $past(PADDR_I) == 8'h0c)
    || ($past(apb_wr, 2) && $past(PADDR_I, 2) == 8'h0c)
    || !$past(otp_q_r, 2))
    else $error("slave current limit changed without cause");
  slave_dis_a: assert property ($changed(DISCHARGE1_O) |->
    ($past(apb_wr) && $past(PADDR_I) == 8'h08)
    || ($past(apb_wr, 2) && $past(PADDR_I, 2) == 8'h08)
    || !$past(otp_q_r, 2))
    else $error("slave discharge changed without cause");
  interleave_dual_a: assert property (INTERLEAVE_180_O |-> DUAL_PHASE_O || $past(DUAL_PHASE_O))
    else $error("interleave outside dual-phase");
  unmapped_read_a: assert property (PSEL_I && PENABLE_I && !PWRITE_I && PADDR_I > 8'h2c
    |-> PRDATA_O == 32'h0)
    else $error("unmapped read returned data");
  cover property (EXT_CLK_SEL_O);
  cover property (INTERLEAVE_180_O);
  cover property (SPREAD_O);
endmodule : bcc_chk
`default_nettype wire

// file: verification/buck_converter_control_bench.sv
/*
  Self-checking bench for the converter control block.
  Drives APB, OTP defaults, load codes and the sync clock from one 100 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
module buck_converter_control_bench import bcc_pkg::*;;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e; logic [31:0] m;} bcc_reg_type;
  typedef struct {logic [8:0] ld; logic [7:0] c; logic p; logic dl;} bcc_mode_type;
  localparam int MC = 20;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        otp_done = 1'b0;
  logic        act_req = 1'b0;
  logic        ilim_evt = 1'b0;
  logic        sync = 1'b0;
  logic [8:0]  ld0 = 9'h000;
  logic [8:0]  ld1 = 9'h000;
  logic [31:0] prdata, q;
  logic        pready, pslverr, pwm0, pwm1, dual, ph1, il180, spread, extsel, pllon, dis1, irq;
  logic [2:0]  slave_current_limit;
  int          fail_count = 0;
  int          check_count = 0;
  int          sh = 0;
  int          cnt = 0;
  int          n;
  bcc_reg_type  regs[6] = '{'{8'h14, 32'h0a, 32'h0a, 32'h9f}, '{8'h14, 32'h19, 32'h0a, 32'h9f},
    '{8'h14, 32'h00, 32'h0a, 32'h9f}, '{8'h14, 32'h18, 32'h18, 32'h9f},
    '{8'h30, 32'hff, 32'h00, 32'hffffffff}, '{8'h1c, 32'h0f, 32'h0f, 32'h0f}};
  bcc_mode_type modes[6] = '{'{9'h01d, 8'h00, 1'b0, 1'b0}, '{9'h01e, 8'h00, 1'b1, 1'b0},
    '{9'h000, 8'h01, 1'b1, 1'b0}, '{9'h1ff, 8'h00, 1'b1, 1'b0},
    '{9'h000, 8'h02, 1'b1, 1'b1}, '{9'h000, 8'h00, 1'b0, 1'b0}};
  always #5 clk = ~clk;
  // Sync clock: half period of sh cycles, low while stopped
  always @(posedge clk) begin
    cnt  <= (sh == 0 || cnt >= sh - 1) ? 0 : cnt + 1;
    sync <= (sh == 0) ? 1'b0 : (cnt >= sh - 1) ? ~sync : sync;
  end
  bcc_top #(.MEAS_CYC(MC)) i_bcc_top (
    .REF_CLK_I(clk), .RST_B_I(rst_b), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
    .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .OTP_DONE_I(otp_done), .OTP_CTRL0_I(8'h00), .OTP_CTRL1_I(8'h04),
    .OTP_ILIM_I(8'h05), .ACTIVE_REQ_I(act_req), .LOAD0_I(ld0), .LOAD1_I(ld1),
    .ILIM0_EVT_I(1'b0), .SLAVE_CURRENT_LIMIT_EVT_I(ilim_evt), .SYNC_CLOCK_INPUT_I(sync), .PWM0_O(pwm0),
    .PWM1_O(pwm1), .DUAL_PHASE_O(dual), .PHASE1_ON_O(ph1), .INTERLEAVE_180_O(il180),
    .SPREAD_O(spread), .EXT_CLK_SEL_O(extsel), .PLL_ON_O(pllon), .DISCHARGE1_O(dis1),
    .SLAVE_CURRENT_LIMIT_O(slave_current_limit), .IRQ_O(irq));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    q = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    apb(1'b0, a, 32'h0);
    chk(q & m, e);
  endtask : rd
  task automatic wait_lvl(input int which, input logic lvl, input int lim);
    n = 0;
    while ((which != 0 ? extsel : irq) !== lvl && n < lim) begin
      n++;
      @(posedge clk);
    end
    if (n >= lim) fail_count++;
  endtask : wait_lvl
  task automatic close_out;
    if (fail_count == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : close_out
  initial begin
    repeat (40000) @(posedge clk);
    fail_count++;
    close_out;
  end
  initial begin
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    otp_done <= 1'b1;
    repeat (4) @(posedge clk);
    chk(32'({dis1, slave_current_limit}), 32'hd);
    rd(8'h0c, 32'h5, 32'h7);
    foreach (regs[i]) begin
      apb(1'b1, regs[i].a, regs[i].d);
      rd(regs[i].a, regs[i].e, regs[i].m);
    end
    foreach (modes[i]) begin
      ld0 <= modes[i].ld;
      apb(1'b1, 8'h00, 32'(modes[i].c));
      repeat (4) @(posedge clk);
      chk(32'({pwm0, dual}), 32'({modes[i].p, modes[i].dl}));
      chk(32'(pwm1), 32'(modes[i].dl));
    end
    // Measurement at light load, flag unmasked
    ld0 <= 9'h00a;
    apb(1'b1, 8'h1c, 32'h0e);
    apb(1'b1, 8'h20, 32'h0);
    repeat (2) @(posedge clk);
    chk(32'({pwm0, pwm1}), 32'h2);
    wait_lvl(0, 1'b1, 100);
    chk(32'(n < MC + 4), 32'h1);
    rd(8'h24, 32'h0a, 32'hff);
    rd(8'h28, 32'h0, 32'h1);
    apb(1'b1, 8'h18, 32'h1);
    chk(32'(irq), 32'h0);
    // Dual-phase: summed result, slave exceptions
    apb(1'b1, 8'h10, 32'h2);
    ld0 <= 9'h123;
    ld1 <= 9'h010;
    apb(1'b1, 8'h20, 32'h0);
    rd(8'h24, 32'h0a, 32'hff);
    wait_lvl(0, 1'b1, 100);
    rd(8'h24, 32'h33, 32'hff);
    rd(8'h28, 32'h1, 32'h1);
    chk(32'({ph1, il180}), 32'h3);
    // Summed load beyond the top code saturates
    ld0 <= 9'h1ff;
    apb(1'b1, 8'h20, 32'h0);
    repeat (MC + 4) @(posedge clk);
    rd(8'h24, 32'hff, 32'hff);
    rd(8'h28, 32'h1, 32'h1);
    ld0 <= 9'h020;
    ld1 <= 9'h000;
    apb(1'b1, 8'h0c, 32'h3);
    apb(1'b1, 8'h08, 32'h0);
    repeat (2) @(posedge clk);
    chk(32'({ph1, dis1, slave_current_limit}), 32'h3);
    ilim_evt <= 1'b1;
    @(posedge clk);
    ilim_evt <= 1'b0;
    rd(8'h18, 32'h4, 32'h4);
    apb(1'b1, 8'h18, 32'hf);
    apb(1'b1, 8'h1c, 32'hf);
    apb(1'b1, 8'h20, 32'h1);
    repeat (MC + 10) @(posedge clk);
    chk(32'(irq), 32'h0);
    rd(8'h18, 32'h1, 32'h1);
    // Spread spectrum and sync clock
    ld0 <= 9'h000;
    apb(1'b1, 8'h10, 32'h1);
    chk(32'(spread), 32'h1);
    apb(1'b1, 8'h14, 32'h8a);
    chk(32'({spread, pllon}), 32'h1);
    apb(1'b1, 8'h18, 32'hf);
    apb(1'b1, 8'h1c, 32'hd);
    sh <= 3;
    repeat (3000) @(posedge clk);
    chk(32'(extsel), 32'h0);
    sh <= 5;
    wait_lvl(1, 1'b1, 3000);
    repeat (3) @(posedge clk);
    chk(32'({extsel, irq}), 32'h3);
    apb(1'b1, 8'h18, 32'h2);
    sh <= 0;
    wait_lvl(1, 1'b0, 3000);
    repeat (3) @(posedge clk);
    chk(32'({extsel, irq}), 32'h1);
    apb(1'b1, 8'h14, 32'h0a);
    apb(1'b1, 8'h18, 32'hf);
    sh <= 5;
    repeat (2500) @(posedge clk);
    chk(32'({pllon, extsel, irq}), 32'h0);
    sh <= 0;
    apb(1'b1, 8'h14, 32'h8a);
    repeat (2500) @(posedge clk);
    apb(1'b1, 8'h18, 32'hf);
    apb(1'b1, 8'h1c, 32'hf);
    act_req <= 1'b1;
    repeat (20) @(posedge clk);
    chk(32'(irq), 32'h0);
    rd(8'h18, 32'h2, 32'h2);
    close_out;
  end
endmodule : buck_converter_control_bench
bind bcc_top bcc_chk i_bcc_chk (
  .REF_CLK_I(REF_CLK_I), .RST_B_I(RST_B_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
  .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O),
  .PSLVERR_O(PSLVERR_O), .OTP_DONE_I(OTP_DONE_I), .LOAD0_I(LOAD0_I), .PWM0_O(PWM0_O),
  .DUAL_PHASE_O(DUAL_PHASE_O), .INTERLEAVE_180_O(INTERLEAVE_180_O), .SPREAD_O(SPREAD_O),
  .EXT_CLK_SEL_O(EXT_CLK_SEL_O), .PLL_ON_O(PLL_ON_O), .DISCHARGE1_O(DISCHARGE1_O),
  .SLAVE_CURRENT_LIMIT_O(SLAVE_CURRENT_LIMIT_O));
`default_nettype wire
